// ==== src/hcpp_device.sv ====
// Purpose: Device end of the host port: sync, decode, access, ready.
// Assumes: Pins are asynchronous; three-stage sync on each input except the straps.
// Notes: Register storage is outside; user side sees access pulses.
module hcpp_device
    import hcpp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    hcpp_if.device pins,
    output logic wr_pulse, // One-cycle write request to registers.
    output logic rd_pulse, // One-cycle read request.
    output logic [6:0] acc_addr, // Latched access address.
    output logic [7:0] wr_data, // Write data.
    input wire logic [7:0] rd_data, // Read data from registers.
    input wire logic irq_pending, // Any enabled interrupt pending.
    output logic [2:0] host_mode // Captured straps.
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001, ST_WAIT = 4'b0010, ST_ACK = 4'b0100, ST_HOLD = 4'b1000
    } hcpp_st_type;

    typedef struct packed {
        logic [2:0] s_ale, s_cs, s_wr, s_rd, s_mrst; // Three-stage syncs.
        logic [7:0] s_ad0, s_ad1, s_ad2; // Data syncs.
        logic [6:0] s_a0, s_a1, s_a2; // Address syncs.
        logic strap_done; // Straps captured since reset.
        logic [2:0] mode; // Captured host type.
        logic [6:0] addr; // Internal address register.
        hcpp_st_type st; // Access state.
        logic is_rd; // Current access is read.
        logic [1:0] dly; // Ack delay count.
        logic [7:0] dout; // Read data held on pins.
        logic [7:0] sh; // Serial shift register.
        logic [3:0] bits; // Serial bit count.
        logic wr_p, rd_p, rdy, irq; // Registered outputs.
        logic [7:0] wdat; // Captured write data.
        logic ale_lvl; // Filtered latch strobe level, low after reset like its pin.
    } hcpp_dev_type;

    hcpp_dev_type q_r, q_nxt;

    // Helper: a synchronised level counts once stages two and three agree.
    // A fall is a new agreed low against a filtered level that was high.
    // Stage 0 is never read here, so a metastable first stage cannot leak.
    function automatic logic fall(input logic [2:0] s, input logic lvl);
        fall = (s[2] == s[1]) && s[1] == 1'b0 && lvl;
    endfunction

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // Stage 0 is the newest sample; only stage 1 reads stage 0.
    always_comb
    begin
        logic serial;
        logic cs_on;
        logic wr_on;
        logic rd_on;
        serial = (q_r.mode == MODE_SERIAL);
        cs_on = (q_r.s_cs[2] == q_r.s_cs[1]) && !q_r.s_cs[2];
        rd_on = 1'b0;
        wr_on = 1'b0;
        q_nxt = q_r;
        q_nxt.s_ale = {q_r.s_ale[1:0], pins.addr_latch};
        q_nxt.s_cs = {q_r.s_cs[1:0], pins.chip_select_n};
        q_nxt.s_wr = {q_r.s_wr[1:0], pins.write_strobe_n};
        q_nxt.s_rd = {q_r.s_rd[1:0], pins.read_strobe_n};
        q_nxt.s_mrst = {q_r.s_mrst[1:0], pins.master_reset_n};
        // The filtered level only moves once stages two and three agree.
        q_nxt.ale_lvl = (q_r.s_ale[2] == q_r.s_ale[1]) ? q_r.s_ale[2] : q_r.ale_lvl;
        q_nxt.s_ad0 = pins.ad;
        q_nxt.s_ad1 = q_r.s_ad0;
        q_nxt.s_ad2 = q_r.s_ad1;
        q_nxt.s_a0 = pins.addr;
        q_nxt.s_a1 = q_r.s_a0;
        q_nxt.s_a2 = q_r.s_a1;
        q_nxt.wr_p = 1'b0;
        q_nxt.rd_p = 1'b0;
        q_nxt.irq = irq_pending;
        // Straps are caught once, just after reset release.
        if (!q_r.strap_done)
        begin
            q_nxt.mode = pins.host_type_select;
            q_nxt.strap_done = 1'b1;
        end
        // Address latch on the falling strobe; serial uses it as clock.
        if (fall(q_r.s_ale, q_r.ale_lvl) && !serial)
        begin
            q_nxt.addr = (q_r.mode == MODE_MUX) ? q_r.s_ad2[6:0] : q_r.s_a2;
        end
        if (serial && cs_on && fall(q_r.s_ale, q_r.ale_lvl))
        begin
            // Serial data in on address bit zero, shifted on the clock.
            q_nxt.sh = {q_r.sh[6:0], q_r.s_a2[0]};
            q_nxt.bits = q_r.bits + 4'h1;
            if (q_r.bits == 4'h7)
            begin
                q_nxt.addr = {q_r.sh[5:0], q_r.s_a2[0]};
                q_nxt.rd_p = 1'b1;
                q_nxt.bits = 4'h0;
            end
        end
        if (!cs_on)
        begin
            q_nxt.bits = 4'h0;
        end
        // Strobe decode; rw-select mode uses the write pin as direction.
        if (q_r.mode == MODE_RWSEL)
        begin
            rd_on = !q_r.s_rd[2] && q_r.s_rd[1] == q_r.s_rd[2] && q_r.s_wr[2];
            wr_on = !q_r.s_rd[2] && q_r.s_rd[1] == q_r.s_rd[2] && !q_r.s_wr[2];
        end
        else
        begin
            rd_on = !q_r.s_rd[2] && q_r.s_rd[1] == q_r.s_rd[2];
            wr_on = !q_r.s_wr[2] && q_r.s_wr[1] == q_r.s_wr[2];
        end
        case (q_r.st)
            ST_IDLE:
            begin
                q_nxt.rdy = 1'b0;
                // Strobes with select high are ignored.
                if (cs_on && !serial && (rd_on || wr_on))
                begin
                    q_nxt.is_rd = rd_on;
                    q_nxt.dly = 2'(ACK_DLY - 1);
                    q_nxt.st = ST_WAIT;
                    q_nxt.wdat = q_r.s_ad2;
                    q_nxt.wr_p = !rd_on;
                    q_nxt.rd_p = rd_on;
                end
            end
            ST_WAIT:
            begin
                q_nxt.dly = q_r.dly - 2'h1;
                if (q_r.dly == 2'h0)
                begin
                    q_nxt.dout = rd_data;
                    q_nxt.st = ST_ACK;
                end
            end
            ST_ACK:
            begin
                q_nxt.rdy = 1'b1;
                q_nxt.st = ST_HOLD;
            end
            ST_HOLD:
            begin
                // Ready stands until the host releases its strobes.
                if (!rd_on && !wr_on)
                begin
                    q_nxt.rdy = 1'b0;
                    q_nxt.st = ST_IDLE;
                end
            end
            default:
            begin
                q_nxt.st = ST_IDLE;
            end
        endcase
        // Serial read data goes out on bit zero, most significant first.
        if (serial && q_r.rd_p)
        begin
            q_nxt.dout = rd_data;
        end
        else if (serial && cs_on && fall(q_r.s_ale, q_r.ale_lvl) && q_r.bits != 4'h7)
        begin
            q_nxt.dout = {q_r.dout[6:0], 1'b0};
        end
        // A low master reset clears the strap flag, state, address, ready, bit count, read data and interrupt.
        if (q_r.s_mrst[2] == q_r.s_mrst[1] && !q_r.s_mrst[2])
        begin
            q_nxt.strap_done = 1'b0;
            q_nxt.st = ST_IDLE;
            q_nxt.addr = 7'h00;
            q_nxt.rdy = 1'b0;
            q_nxt.bits = 4'h0;
            q_nxt.dout = 8'h00;
            q_nxt.irq = 1'b0;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Asynchronous reset loads constants only.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q_r <= '{s_ale: 3'h0, s_cs: 3'h7, s_wr: 3'h7, s_rd: 3'h7, s_mrst: 3'h7,
                st: ST_IDLE, default: '0};
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // In EPROM mode the device owns the address and select pins.
    assign pins.addr_d_oe = (q_r.mode == MODE_EPROM) && q_r.strap_done;
    assign pins.addr_d_o = q_r.addr;
    assign pins.cs_d_o = 1'b0;
    // Serial output drives only while selected, so a shared bus is left free.
    assign pins.ad_d_oe = (q_r.mode == MODE_SERIAL) ? !pins.chip_select_n : (q_r.rdy && q_r.is_rd);
    assign pins.ad_d_o = (q_r.mode == MODE_SERIAL) ? {7'h00, q_r.dout[7]} : q_r.dout;
    assign pins.ready = q_r.rdy;
    assign pins.interrupt_request = q_r.irq;
    assign wr_pulse = q_r.wr_p;
    assign rd_pulse = q_r.rd_p;
    assign acc_addr = q_r.addr;
    assign wr_data = q_r.wdat;
    assign host_mode = q_r.mode;
endmodule

// ==== src/hcpp_pkg.sv ====
// Purpose: Shared constants for the host CPU port pin front end.
// Assumes: One system clock at 50 MHz; host pins are asynchronous to it.
// Notes: Both ends import this package; no register map is modelled here.
//
// Functional notes
// - Host type chosen by three straps at reset.
// - Seven-bit address; serial mode uses bit zero.
// - EPROM mode: device drives address and select.
// - Host pulls chip select low per access.
// - Write strobe low writes; high reads (rw-mode).
// - Read strobe low starts a read.
// - Latch strobe falling edge captures the address.
// - Serial mode: latch strobe is serial clock.
// - Master reset low returns all state default; device clears strap flag, state, address, ready, bits, read data, irq only.
// - Interrupt request output is active high.
// - Reference oscillator runs at 12.800 MHz.
// - Ready goes high when access completes.
// - Address/data pins multiplexed; bit zero serial out.
package hcpp_pkg;

    // ****************************************************************
    // Widths and modes
    // ****************************************************************
    localparam int ADDR_W = 7; // Register address width.
    localparam int DATA_W = 8; // Address/data bus width.
    localparam int SEL_W = 3; // Host type strap width.

    // Host type strap codes (chosen encoding).
    localparam logic [2:0] MODE_EPROM = 3'h1;
    localparam logic [2:0] MODE_MUX = 3'h2;
    localparam logic [2:0] MODE_RWSEL = 3'h3;
    localparam logic [2:0] MODE_RDWR = 3'h4;
    localparam logic [2:0] MODE_SERIAL = 3'h5;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_HZ = 50_000_000; // System clock rate.
    localparam int REF_KHZ = 12_800; // Reference oscillator, 12.800 MHz.
    localparam int STROBE_NS = 200; // Least host strobe width in ns.
    localparam int STROBE_CYC = (STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int ACK_DLY = 2; // Device cycles in the wait state; ready comes one cycle later.
endpackage

// ==== src/hcpp_if.sv ====
// Purpose: Pin bundle joining the host and the device ends.
// Assumes: Wire levels are resolved here from output enables.
// Notes: Data pins are in, out and enable at each end; address and select use the device enable only.
interface hcpp_if;
    import hcpp_pkg::*;
    logic [2:0] host_type_select; // Straps driven by the host board.
    logic [6:0] addr_h_o; // Address driven by the host.
    logic [6:0] addr_d_o; // Address driven by the device (EPROM).
    logic addr_d_oe; // Device address/select enable.
    logic [6:0] addr; // Resolved address pins.
    logic cs_h_o; // Host chip select drive.
    logic cs_d_o; // Device chip select drive.
    logic chip_select_n; // Resolved select.
    logic write_strobe_n; // Write strobe from host.
    logic read_strobe_n; // Read strobe from host.
    logic addr_latch; // Latch strobe or serial clock.
    logic [7:0] ad_h_o; // Host data drive.
    logic ad_h_oe; // Host data enable.
    logic [7:0] ad_d_o; // Device data drive.
    logic ad_d_oe; // Device data enable.
    logic [7:0] ad; // Resolved data pins.
    logic ready; // Access complete.
    logic interrupt_request; // Active high interrupt.
    logic master_reset_n; // Master reset from host.

    // Pin resolution; unused bus bits fall back to zero (pull-down).
    assign addr = addr_d_oe ? addr_d_o : addr_h_o;
    assign chip_select_n = addr_d_oe ? cs_d_o : cs_h_o;
    assign ad = ad_d_oe ? ad_d_o : (ad_h_oe ? ad_h_o : 8'h00);

    modport device (input host_type_select, input addr, input chip_select_n,
        input write_strobe_n, input read_strobe_n, input addr_latch, input ad,
        input master_reset_n, output addr_d_o, output addr_d_oe, output cs_d_o,
        output ad_d_o, output ad_d_oe, output ready, output interrupt_request);
    modport host (output host_type_select, output addr_h_o, output cs_h_o,
        output write_strobe_n, output read_strobe_n, output addr_latch,
        output ad_h_o, output ad_h_oe, output master_reset_n,
        input addr, input chip_select_n, input ad, input ready,
        input interrupt_request);
endinterface

// ==== src/hcpp_host.sv ====
// Purpose: Host end: drives straps, address, select and strobes.
// Assumes: Parallel access with a separate address phase on the pins.
// Notes: The reference oscillator is supplied by the board, not here.
module hcpp_host
    import hcpp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    hcpp_if.host pins,
    input wire logic [2:0] mode_sel, // Strap value to present.
    input wire logic req_valid, // Start an access.
    input wire logic req_write, // One for write.
    input wire logic [6:0] req_addr, // Register address.
    input wire logic [7:0] req_wdata, // Write data.
    input wire logic sys_reset_req, // Pulse master reset low.
    output logic req_ready, // Idle and able to accept.
    output logic [7:0] rsp_rdata, // Read data.
    output logic rsp_valid // One-cycle completion pulse.
);
    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001, HS_ADDR = 4'b0010, HS_STRB = 4'b0100, HS_END = 4'b1000
    } hcpp_hst_type;

    typedef struct packed {
        hcpp_hst_type st; // Host sequence state.
        logic [2:0] s_rdy; // Ready sync.
        logic [7:0] cnt; // Phase timer.
        logic we, cs_n, ale, wr_n, rd_n, mrst_n, dv; // Pin and flag drives.
        logic [6:0] a; // Address drive.
        logic [7:0] d, rd; // Write and read data.
    } hcpp_host_type;

    hcpp_host_type q_r, q_nxt;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb
    begin
        q_nxt = q_r;
        q_nxt.s_rdy = {q_r.s_rdy[1:0], pins.ready};
        q_nxt.dv = 1'b0;
        q_nxt.mrst_n = !sys_reset_req;
        q_nxt.cnt = (q_r.cnt == 8'h00) ? 8'h00 : q_r.cnt - 8'h01;
        case (q_r.st)
            HS_IDLE:
            begin
                if (req_valid)
                begin
                    q_nxt.a = req_addr;
                    q_nxt.d = req_wdata;
                    q_nxt.we = req_write;
                    q_nxt.cs_n = 1'b0;
                    q_nxt.ale = 1'b1;
                    q_nxt.cnt = 8'(STROBE_CYC);
                    q_nxt.st = HS_ADDR;
                end
            end
            HS_ADDR:
            begin
                // Latch strobe falls half way, so the address outlives it.
                if (q_r.cnt == 8'(STROBE_CYC / 2))
                begin
                    q_nxt.ale = 1'b0;
                end
                if (q_r.cnt == 8'h00)
                begin
                    q_nxt.ale = 1'b0;
                    q_nxt.wr_n = !q_r.we;
                    // In rw-select style the read pin is the data strobe.
                    q_nxt.rd_n = (mode_sel == MODE_RWSEL) ? 1'b0 : q_r.we;
                    q_nxt.st = HS_STRB;
                end
            end
            HS_STRB:
            begin
                if (q_r.s_rdy[2] && q_r.s_rdy[1])
                begin
                    q_nxt.rd = pins.ad;
                    q_nxt.wr_n = 1'b1;
                    q_nxt.rd_n = 1'b1;
                    q_nxt.st = HS_END;
                end
            end
            HS_END:
            begin
                if (!q_r.s_rdy[2] && !q_r.s_rdy[1])
                begin
                    q_nxt.cs_n = 1'b1;
                    q_nxt.dv = 1'b1;
                    q_nxt.st = HS_IDLE;
                end
            end
            default:
            begin
                q_nxt.st = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q_r <= '{st: HS_IDLE, cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, mrst_n: 1'b0,
                default: '0};
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    // Straps stay steady; the device catches them at reset.
    assign pins.host_type_select = mode_sel;
    assign pins.addr_h_o = q_r.a;
    assign pins.cs_h_o = q_r.cs_n;
    assign pins.write_strobe_n = q_r.wr_n;
    assign pins.read_strobe_n = q_r.rd_n;
    assign pins.addr_latch = q_r.ale;
    assign pins.ad_h_o = (q_r.st == HS_ADDR) ? {1'b0, q_r.a} : q_r.d;
    // Write data is driven only inside the strobe phase, never while idle.
    assign pins.ad_h_oe = (q_r.we && (q_r.st == HS_STRB)) || (q_r.st == HS_ADDR);
    assign pins.master_reset_n = q_r.mrst_n;
    assign req_ready = (q_r.st == HS_IDLE);
    assign rsp_rdata = q_r.rd;
    assign rsp_valid = q_r.dv;
endmodule

// ==== test/hcpp_checker.sv ====
// Purpose: Pin-level protocol checks on the host port bundle.
// Assumes: One clock domain; rst_b low resets both ends.
// Notes: Sees the resolved pins and the output enables of the bundle, never the user sides.
module hcpp_checker
    import hcpp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [2:0] host_type_select,
    input wire logic addr_d_oe,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic addr_latch,
    input wire logic ad_h_oe,
    input wire logic ad_d_oe,
    input wire logic ready,
    input wire logic interrupt_request,
    input wire logic master_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // Assertions
    // ************************************************************
    // Every check shares the system clock and the bench reset.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // Ready may only rise for a selected access with a strobe low.
    ready_has_cs_a: assert property ($rose(ready) |->
        !chip_select_n && !(read_strobe_n && write_strobe_n))
        else $error("ready rose without a selected strobe");
    // Ready must drop soon after both strobes are released.
    ready_drops_a: assert property (ready && read_strobe_n && write_strobe_n |->
        ##[1:8] !ready) else $error("ready held after strobes released");
    // A read strobe is only given while the device is selected.
    rd_needs_cs_a: assert property (!read_strobe_n |-> !chip_select_n)
        else $error("read strobe low while deselected");
    // A write cycle only starts while the device is selected.
    wr_needs_cs_a: assert property ($fell(write_strobe_n) |-> !chip_select_n)
        else $error("write strobe fell while deselected");
    // The device drives address and select in the boot mode only.
    eprom_drive_a: assert property (addr_d_oe |-> host_type_select == MODE_EPROM)
        else $error("device drove address outside boot mode");
    // Read data is driven only while chip select is low.
    data_select_a: assert property (ad_d_oe && !addr_d_oe |-> !chip_select_n)
        else $error("device drove data while deselected");
    // Both ends driving the data pins at once would clash.
    no_clash_a: assert property (!(ad_d_oe && ad_h_oe))
        else $error("both ends drive the data pins");
    // The address is latched only inside a selected access.
    latch_select_a: assert property ($fell(addr_latch) |-> !chip_select_n)
        else $error("address latched while deselected");
    // A held master reset silences ready and the interrupt.
    // Three sync stages plus one register lag the pin by four edges.
    reset_quiet_a: assert property (!master_reset_n [*5] |->
        !ready && !interrupt_request) else $error("outputs active in master reset");

    // Main scenarios reached.
    cover property ($rose(ready) && !write_strobe_n && read_strobe_n);
    cover property ($rose(ready) && !read_strobe_n);
    cover property ($rose(interrupt_request));
    cover property (addr_d_oe);
endmodule

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench joining the host end to the device end.
// Assumes: 50 MHz clock; inputs change on the falling edge.
// Notes: Drivers queue expected results; a monitor pops and compares.
module tb_top;
    import hcpp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys, rst_b, req_valid, req_write, sys_reset_req, irq_pending;
    logic req_ready, rsp_valid, wr_pulse, rd_pulse;
    logic [2:0] mode_sel, host_mode;
    logic [6:0] req_addr, acc_addr;
    logic [7:0] req_wdata, rsp_rdata, wr_data, rd_data;
    logic [15:0] dev_q[$]; // Expected {write, address, data} at the device.
    logic [8:0] rsp_q[$]; // Expected {is read, read data} per host completion.
    logic [15:0] exp_v;
    logic [8:0] exp_r; // Oldest completion note.
    int errors, checks;
    logic [2:0] mlist[3] = '{MODE_MUX, MODE_RWSEL, MODE_RDWR};

    // ************************************************************
    // Design, bundle and checker
    // ************************************************************
    hcpp_if hcpp_if_i ();
    hcpp_host hcpp_host_i (.clk_sys(clk_sys), .rst_b(rst_b), .pins(hcpp_if_i),
        .mode_sel(mode_sel), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .sys_reset_req(sys_reset_req),
        .req_ready(req_ready), .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid));
    hcpp_device hcpp_device_i (.clk_sys(clk_sys), .rst_b(rst_b), .pins(hcpp_if_i),
        .wr_pulse(wr_pulse), .rd_pulse(rd_pulse), .acc_addr(acc_addr),
        .wr_data(wr_data), .rd_data(rd_data), .irq_pending(irq_pending),
        .host_mode(host_mode));
    hcpp_checker hcpp_checker_i (.clk_sys(clk_sys), .rst_b(rst_b),
        .host_type_select(hcpp_if_i.host_type_select), .addr_d_oe(hcpp_if_i.addr_d_oe),
        .chip_select_n(hcpp_if_i.chip_select_n), .write_strobe_n(hcpp_if_i.write_strobe_n),
        .read_strobe_n(hcpp_if_i.read_strobe_n), .addr_latch(hcpp_if_i.addr_latch),
        .ad_h_oe(hcpp_if_i.ad_h_oe), .ad_d_oe(hcpp_if_i.ad_d_oe), .ready(hcpp_if_i.ready),
        .interrupt_request(hcpp_if_i.interrupt_request),
        .master_reset_n(hcpp_if_i.master_reset_n));

    // Free-running 20 ns clock.
    initial clk_sys = 1'b0;
    always #10 clk_sys = ~clk_sys;

    // ************************************************************
    // Shared tasks
    // ************************************************************
    // Counts one comparison and reports a mismatch at once.
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One host access; waits are bounded so a hang shows as a mismatch.
    task automatic access(input logic wr, input logic [6:0] a);
        int n;
        logic [7:0] d;
        n = 0;
        d = 8'($urandom);
        while (req_ready !== 1'b1 && n < 200)
        begin
            @(negedge clk_sys);
            n++;
        end
        rd_data = 8'($urandom);
        if (wr)
        begin
            dev_q.push_back({1'b1, a, d});
            rsp_q.push_back({1'b0, 8'h00});
        end
        else
        begin
            dev_q.push_back({1'b0, a, 8'h00});
            rsp_q.push_back({1'b1, rd_data});
        end
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        @(negedge clk_sys);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 300)
        begin
            @(negedge clk_sys);
            n++;
        end
        check(16'(n < 300), 16'h0001);
        @(negedge clk_sys);
    endtask

    // Pulses master reset with new straps; the device must re-capture them.
    task automatic set_mode(input logic [2:0] m);
        mode_sel = m;
        sys_reset_req = 1'b1;
        repeat (8) @(negedge clk_sys);
        sys_reset_req = 1'b0;
        repeat (12) @(negedge clk_sys);
        check({13'h0, host_mode}, {13'h0, m});
    endtask

    // ************************************************************
    // Monitor
    // ************************************************************
    // Pulses last one cycle, so each is seen at exactly one falling edge.
    always @(negedge clk_sys)
    begin
        if (rst_b && (wr_pulse || rd_pulse))
        begin
            exp_v = (dev_q.size() > 0) ? dev_q.pop_front() : 16'hxxxx;
            check({wr_pulse, acc_addr, wr_pulse ? wr_data : 8'h00}, exp_v);
        end
        // Every access completes once; only reads carry data to compare.
        if (rst_b && rsp_valid)
        begin
            exp_r = (rsp_q.size() > 0) ? rsp_q.pop_front() : 9'h1xx;
            if (exp_r[8])
                check({8'h00, rsp_rdata}, {8'h00, exp_r[7:0]});
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        rst_b = 1'b0;
        mode_sel = MODE_MUX;
        {req_valid, req_write, sys_reset_req, irq_pending} = 4'h0;
        req_addr = 7'h00;
        req_wdata = 8'h00;
        rd_data = 8'h00;
        void'($urandom(32'hc345));
        repeat (4) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (6) @(negedge clk_sys);
        check({13'h0, host_mode}, {13'h0, MODE_MUX});
        // Boundary addresses back to back, then random traffic per mode.
        for (int i = 0; i < 3; i++)
        begin
            set_mode(mlist[i]);
            access(1'b1, 7'h7f);
            access(1'b0, 7'h7f);
            access(1'b1, 7'h00);
            access(1'b0, 7'h00);
            repeat (4) access(1'($urandom), 7'($urandom));
        end
        // Interrupt follows its source, and is high again after a master reset while the source stays high.
        irq_pending = 1'b1;
        repeat (6) @(negedge clk_sys);
        check({15'h0, hcpp_if_i.interrupt_request}, 16'h0001);
        set_mode(MODE_SERIAL);
        check({15'h0, hcpp_if_i.interrupt_request}, 16'h0001);
        irq_pending = 1'b0;
        repeat (6) @(negedge clk_sys);
        check({15'h0, hcpp_if_i.interrupt_request}, 16'h0000);
        // Boot mode is last, because the straps never leave it again.
        set_mode(MODE_EPROM);
        repeat (40) @(negedge clk_sys);
        check(16'(dev_q.size() + rsp_q.size()), 16'h0000);
        tally_and_finish();
    end

    // Watchdog: the tests need well under 10,000 cycles.
    initial
    begin
        #400_000;
        errors++;
        $display("ERROR t=%0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule
